// ==== logic/pwdf_bus_adapter.sv ====
// Pin adapter: two-flop synchroniser per pin plus a rising-edge pulse.
// Assumes pins are asynchronous to core_clk_i and held long enough to be seen.
`timescale 1ns/1ns
module pwdf_bus_adapter #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         reset_i,
  input  wire logic         ce_i,
  // Pins and their synchronised forms
  input  wire logic [W-1:0] pins_i,
  output logic      [W-1:0] level_o,
  output logic      [W-1:0] rise_o
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] prev_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_sync;
  logic [W-1:0] nxt_prev;

  if (W < 1) begin : g_chk
    $error("pwdf_bus_adapter needs at least one pin");
  end

  always_comb begin
    nxt_meta = pins_i;
    nxt_sync = meta_ff;
    nxt_prev = sync_ff;
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
      prev_ff <= '0;
    end else if (ce_i) begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      prev_ff <= nxt_prev;
    end
  end

  assign level_o = sync_ff;
  assign rise_o  = sync_ff & ~prev_ff;
endmodule

// ==== logic/pwdf_defs.svh ====
// Constants of the plasma wave data formatter: frame layout, rates and codes.
// Assumes inclusion by bare name from files under logic/ and test/.
`ifndef PWDF_DEFS_SVH
`define PWDF_DEFS_SVH
`define PWDF_WORD_W         8
`define PWDF_LR_WORDS       20
`define PWDF_LR_SCI_WORDS   18
`define PWDF_LR_BITS        160
`define PWDF_LR_LAST_WORD   5'h13
`define PWDF_LR_ENG_WORD    5'h01
`define PWDF_SV_LAST_CONV   5'h09
`define PWDF_FRAMES         5'h1c
`define PWDF_SURVEY_HALF    5'h0e
`define PWDF_SV_SAMPLES     9'h118
`define PWDF_SV_PER_FRAME   9'h00a
`define PWDF_SV_FIRST_WORD  5'h0a
`define PWDF_HR_BIT_HZ      806400
`define PWDF_RATE_M1_BPS    100800
`define PWDF_RATE_M2_BPS    806400
`define PWDF_RATE_M3_BPS    12600
`define PWDF_TICKS_M1       (8 * `PWDF_HR_BIT_HZ / `PWDF_RATE_M1_BPS)
`define PWDF_TICKS_M2       (8 * `PWDF_HR_BIT_HZ / `PWDF_RATE_M2_BPS)
`define PWDF_TICKS_M3       (8 * `PWDF_HR_BIT_HZ / `PWDF_RATE_M3_BPS)
`define PWDF_CAL_HZ         960
`define PWDF_CAL_HALF_TICKS (`PWDF_HR_BIT_HZ / (2 * `PWDF_CAL_HZ))
`define PWDF_SYNC0          8'heb
`define PWDF_SYNC1          8'h90
`define PWDF_CMD_EN_BIT     7
`define PWDF_CMD_ANT_BIT    6
`define PWDF_CMD_CAL_BIT    5
`define PWDF_CMD_RST        8'h00
`endif

// ==== logic/pwdf_pkg.sv ====
// Types shared by the plasma wave data formatter files.
// Assumes nothing of its surroundings.
package pwdf_pkg;
  typedef enum logic [2:0] {
    LR_IDLE  = 3'b001,
    LR_CONV  = 3'b010,
    LR_SHIFT = 3'b100
  } pwdf_lr_state_t;
  typedef enum logic [1:0] {
    MODE_1      = 2'h0,
    MODE_2      = 2'h1,
    MODE_3      = 2'h2,
    MODE_SURVEY = 2'h3
  } pwdf_mode_t;
  typedef enum logic [1:0] {
    BAND_LOW  = 2'h0,
    BAND_MID  = 2'h1,
    BAND_HIGH = 2'h2
  } pwdf_band_t;
endpackage

// ==== logic/pwdf_top.sv ====
// Plasma wave data formatter: low-rate 20-word block, hi-rate stream, survey buffer.
// Assumes host bus timing pins, converter handshake and command strobe are asynchronous.
`timescale 1ns/1ns
`include "pwdf_defs.svh"
module pwdf_top #(
  parameter int HR_BLOCK = 64
) (
  // Clock and reset
  input  wire logic               core_clk_i,
  input  wire logic               reset_i,
  input  wire logic               ce_i,
  // Host bus timing and command pins
  input  wire logic               host_bit_clk_i,
  input  wire logic               host_frame_i,
  input  wire logic               host_hr_clk_i,
  input  wire logic               host_cmd_stb_i,
  input  wire logic [7:0]         host_cmd_data_i,
  // Low-rate serial output
  output logic                    lr_data_o,
  output logic                    lr_ready_o,
  // Hi-rate output to bulk memory
  output logic [7:0]              hr_data_o,
  output logic                    hr_valid_o,
  // Converter handshake
  output logic                    adc_start_o,
  output logic [4:0]              adc_chan_o,
  input  wire logic               adc_done_i,
  input  wire logic [7:0]         adc_data_i,
  input  wire logic [7:0]         wf_data_i,
  // Analog steering
  output pwdf_pkg::pwdf_band_t    wf_band_o,
  output logic                    antenna_b_o,
  output logic                    cal_wave_o
);
  import pwdf_pkg::*;

  if (HR_BLOCK < 3 || HR_BLOCK > 256) begin : g_chk
    $error("HR_BLOCK must lie in 3..256");
  end

  // Pin synchronisation.
  logic [4:0]  ctl_lvl;
  logic [4:0]  ctl_rise;
  logic [23:0] dat_lvl;
  logic        bit_rise;
  logic        frame_rise;
  logic        hr_rise;
  logic        cmd_rise;
  logic        done_rise;

  pwdf_bus_adapter #(.W(5)) u_ctl (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .ce_i       (ce_i),
    .pins_i     ({adc_done_i, host_cmd_stb_i, host_hr_clk_i, host_frame_i, host_bit_clk_i}),
    .level_o    (ctl_lvl),
    .rise_o     (ctl_rise)
  );

  pwdf_bus_adapter #(.W(24)) u_dat (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .ce_i       (ce_i),
    .pins_i     ({wf_data_i, adc_data_i, host_cmd_data_i}),
    .level_o    (dat_lvl),
    .rise_o     ()
  );

  assign bit_rise   = ctl_rise[0];
  assign frame_rise = ctl_rise[1];
  assign hr_rise    = ctl_rise[2];
  assign cmd_rise   = ctl_rise[3];
  assign done_rise  = ctl_rise[4];

  // Byte period of the hi-rate stream in host hi-rate clock ticks.
  function automatic logic [9:0] hr_ticks(input logic [7:0] cmd, input logic [4:0] fr);
    logic [1:0] m;
    m = cmd[1:0];
    case (m)
      MODE_1:  hr_ticks = 10'(`PWDF_TICKS_M1);
      MODE_2:  hr_ticks = 10'(`PWDF_TICKS_M2);
      MODE_3:  hr_ticks = 10'(`PWDF_TICKS_M3);
      default: hr_ticks = (fr < `PWDF_SURVEY_HALF) ? 10'(`PWDF_TICKS_M3)
                                                   : 10'(`PWDF_TICKS_M1);
    endcase
  endfunction

  // Storage: low-rate words and the survey buffer.
  logic [7:0] lr_buf [0:`PWDF_LR_WORDS-1];
  logic [7:0] sv_buf [0:`PWDF_SV_SAMPLES-1];

  // State.
  pwdf_lr_state_t lr_state_ff, nxt_lr_state;
  pwdf_band_t     band_ff, nxt_band;
  logic [7:0] cmd_ff,       nxt_cmd;
  logic [4:0] frame_cnt_ff, nxt_frame_cnt;
  logic [4:0] word_ff,      nxt_word;
  logic [7:0] bit_cnt_ff,   nxt_bit_cnt;
  logic       lr_data_ff,   nxt_lr_data;
  logic       lr_ready_ff,  nxt_lr_ready;
  logic       adc_start_ff, nxt_adc_start;
  logic [4:0] adc_chan_ff,  nxt_adc_chan;
  logic       survey_ff,    nxt_survey;
  logic [8:0] sv_wr_ff,     nxt_sv_wr;
  logic [8:0] sv_rd_ff,     nxt_sv_rd;
  logic       sv_full_ff,   nxt_sv_full;
  logic [9:0] hr_div_ff,    nxt_hr_div;
  logic [7:0] hr_idx_ff,    nxt_hr_idx;
  logic [7:0] hr_data_ff,   nxt_hr_data;
  logic       hr_valid_ff,  nxt_hr_valid;
  logic [8:0] cal_cnt_ff,   nxt_cal_cnt;
  logic       cal_ff,       nxt_cal;

  // Memory write ports.
  logic       lr_we;
  logic [4:0] lr_waddr;
  logic [7:0] lr_wdata;
  logic       sv_we;
  logic [8:0] sv_waddr;
  logic [7:0] cur_word;
  logic [8:0] sv_raddr;
  logic       enabled;
  logic       in_survey;

  assign enabled   = cmd_ff[`PWDF_CMD_EN_BIT];
  assign in_survey = (cmd_ff[1:0] == MODE_SURVEY);

  always_comb begin
    nxt_lr_state  = lr_state_ff;
    nxt_band      = band_ff;
    nxt_cmd       = cmd_ff;
    nxt_frame_cnt = frame_cnt_ff;
    nxt_word      = word_ff;
    nxt_bit_cnt   = bit_cnt_ff;
    nxt_lr_data   = lr_data_ff;
    nxt_lr_ready  = lr_ready_ff;
    nxt_adc_start = 1'b0;
    nxt_adc_chan  = adc_chan_ff;
    nxt_survey    = survey_ff;
    nxt_sv_wr     = sv_wr_ff;
    nxt_sv_rd     = sv_rd_ff;
    nxt_sv_full   = sv_full_ff;
    nxt_hr_div    = hr_div_ff;
    nxt_hr_idx    = hr_idx_ff;
    nxt_hr_data   = hr_data_ff;
    nxt_hr_valid  = 1'b0;
    nxt_cal_cnt   = cal_cnt_ff;
    nxt_cal       = cal_ff;
    lr_we         = 1'b0;
    lr_waddr      = word_ff;
    lr_wdata      = dat_lvl[15:8];
    sv_we         = 1'b0;
    sv_waddr      = sv_wr_ff;

    // Commands are taken only between frames so a block mixes two settings only when cmd_rise and frame_rise share a cycle.
    if (cmd_rise && lr_state_ff == LR_IDLE) begin
      nxt_cmd = dat_lvl[7:0];
    end

    // Band follows mode; survey band flips with the frame half.
    case (cmd_ff[1:0])
      MODE_1:  nxt_band = BAND_MID;
      MODE_2:  nxt_band = BAND_HIGH;
      MODE_3:  nxt_band = BAND_LOW;
      default: nxt_band = (frame_cnt_ff < `PWDF_SURVEY_HALF) ? BAND_LOW : BAND_MID;
    endcase

    // Status word: antenna, frame counter, command bit pair, MSB first.
    cur_word = lr_buf[bit_cnt_ff[7:3]];
    sv_raddr = sv_rd_ff + 9'(bit_cnt_ff[7:3] - `PWDF_SV_FIRST_WORD);
    if (bit_cnt_ff[7:3] == 5'h00) begin
      cur_word = {cmd_ff[`PWDF_CMD_ANT_BIT], frame_cnt_ff, 2'h0};
      case (frame_cnt_ff[1:0])
        2'h0:    cur_word[1:0] = cmd_ff[7:6];
        2'h1:    cur_word[1:0] = cmd_ff[5:4];
        2'h2:    cur_word[1:0] = cmd_ff[3:2];
        default: cur_word[1:0] = cmd_ff[1:0];
      endcase
    end else if (survey_ff && bit_cnt_ff[7:3] >= `PWDF_SV_FIRST_WORD) begin
      cur_word = sv_buf[sv_raddr];
    end

    case (lr_state_ff)
      LR_IDLE: begin
        if (frame_rise && enabled) begin
          nxt_lr_state  = LR_CONV;
          nxt_survey    = in_survey;
          nxt_word      = `PWDF_LR_ENG_WORD;
          nxt_adc_chan  = 5'h00;
          nxt_adc_start = 1'b1;
        end
      end
      LR_CONV: begin
        if (done_rise) begin
          lr_we = 1'b1;
          if (word_ff == (survey_ff ? `PWDF_SV_LAST_CONV : `PWDF_LR_LAST_WORD)) begin
            nxt_lr_state = LR_SHIFT;
            nxt_lr_ready = 1'b1;
            nxt_bit_cnt  = 8'h00;
          end else begin
            nxt_word      = word_ff + 5'h01;
            nxt_adc_chan  = adc_chan_ff + 5'h01;
            nxt_adc_start = 1'b1;
          end
        end
      end
      LR_SHIFT: begin
        if (bit_rise) begin
          nxt_lr_data = cur_word[~bit_cnt_ff[2:0]];
          nxt_bit_cnt = bit_cnt_ff + 8'h01;
          if (bit_cnt_ff == 8'(`PWDF_LR_BITS - 1)) begin
            nxt_lr_state  = LR_IDLE;
            nxt_lr_ready  = 1'b0;
            nxt_frame_cnt = (frame_cnt_ff == `PWDF_FRAMES - 5'h01) ? 5'h00
                                                                  : frame_cnt_ff + 5'h01;
            if (survey_ff && sv_full_ff) begin
              if (sv_rd_ff + `PWDF_SV_PER_FRAME >= `PWDF_SV_SAMPLES) begin
                nxt_sv_rd   = 9'h000;
                nxt_sv_wr   = 9'h000;
                nxt_sv_full = 1'b0;
              end else begin
                nxt_sv_rd = sv_rd_ff + `PWDF_SV_PER_FRAME;
              end
            end
          end
        end
      end
      default: nxt_lr_state = LR_IDLE;
    endcase

    // Hi-rate stream paced by the host hi-rate clock.
    if (hr_rise && enabled) begin
      if (hr_div_ff >= hr_ticks(cmd_ff, frame_cnt_ff) - 10'h001) begin
        nxt_hr_div   = 10'h000;
        nxt_hr_valid = 1'b1;
        nxt_hr_idx   = (hr_idx_ff == 8'(HR_BLOCK - 1)) ? 8'h00 : hr_idx_ff + 8'h01;
        if (hr_idx_ff == 8'h00) begin
          nxt_hr_data = `PWDF_SYNC0;
        end else if (hr_idx_ff == 8'h01) begin
          nxt_hr_data = `PWDF_SYNC1;
        end else begin
          nxt_hr_data = dat_lvl[23:16];
          if (in_survey && !sv_full_ff) begin
            sv_we     = 1'b1;
            nxt_sv_wr = sv_wr_ff + 9'h001;
            if (sv_wr_ff == `PWDF_SV_SAMPLES - 9'h001) begin
              nxt_sv_full = 1'b1;
            end
          end
        end
      end else begin
        nxt_hr_div = hr_div_ff + 10'h001;
      end
    end

    // Calibration square wave from host hi-rate ticks.
    if (hr_rise) begin
      if (cal_cnt_ff == 9'(`PWDF_CAL_HALF_TICKS - 1)) begin
        nxt_cal_cnt = 9'h000;
        nxt_cal     = ~cal_ff & cmd_ff[`PWDF_CMD_CAL_BIT];
      end else begin
        nxt_cal_cnt = cal_cnt_ff + 9'h001;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (ce_i && lr_we) begin
      lr_buf[lr_waddr] <= lr_wdata;
    end
    if (ce_i && sv_we) begin
      sv_buf[sv_waddr] <= dat_lvl[23:16];
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      lr_state_ff  <= LR_IDLE;
      band_ff      <= BAND_MID;
      cmd_ff       <= `PWDF_CMD_RST;
      frame_cnt_ff <= 5'h00;
      word_ff      <= 5'h00;
      bit_cnt_ff   <= 8'h00;
      lr_data_ff   <= 1'b0;
      lr_ready_ff  <= 1'b0;
      adc_start_ff <= 1'b0;
      adc_chan_ff  <= 5'h00;
      survey_ff    <= 1'b0;
      sv_wr_ff     <= 9'h000;
      sv_rd_ff     <= 9'h000;
      sv_full_ff   <= 1'b0;
      hr_div_ff    <= 10'h000;
      hr_idx_ff    <= 8'h00;
      hr_data_ff   <= 8'h00;
      hr_valid_ff  <= 1'b0;
      cal_cnt_ff   <= 9'h000;
      cal_ff       <= 1'b0;
    end else if (ce_i) begin
      lr_state_ff  <= nxt_lr_state;
      band_ff      <= nxt_band;
      cmd_ff       <= nxt_cmd;
      frame_cnt_ff <= nxt_frame_cnt;
      word_ff      <= nxt_word;
      bit_cnt_ff   <= nxt_bit_cnt;
      lr_data_ff   <= nxt_lr_data;
      lr_ready_ff  <= nxt_lr_ready;
      adc_start_ff <= nxt_adc_start;
      adc_chan_ff  <= nxt_adc_chan;
      survey_ff    <= nxt_survey;
      sv_wr_ff     <= nxt_sv_wr;
      sv_rd_ff     <= nxt_sv_rd;
      sv_full_ff   <= nxt_sv_full;
      hr_div_ff    <= nxt_hr_div;
      hr_idx_ff    <= nxt_hr_idx;
      hr_data_ff   <= nxt_hr_data;
      hr_valid_ff  <= nxt_hr_valid;
      cal_cnt_ff   <= nxt_cal_cnt;
      cal_ff       <= nxt_cal;
    end
  end

  assign lr_data_o   = lr_data_ff;
  assign lr_ready_o  = lr_ready_ff;
  assign hr_data_o   = hr_data_ff;
  assign hr_valid_o  = hr_valid_ff;
  assign adc_start_o = adc_start_ff;
  assign adc_chan_o  = adc_chan_ff;
  assign wf_band_o   = band_ff;
  assign antenna_b_o = cmd_ff[`PWDF_CMD_ANT_BIT];
  assign cal_wave_o  = cal_ff;
endmodule

// ==== test/pwdf_host_model.sv ====
// Host and converter model: timing pins, command strobes and conversion answers.
// Assumes the formatter syncs pins on core_clk_i; every high level holds six clocks.
`timescale 1ns/1ns
module pwdf_host_model (
  // Clock
  input  wire logic       core_clk_i,
  // Host pins
  output logic            bit_clk_o,
  output logic            frame_o,
  output logic            hr_clk_o,
  output logic            cmd_stb_o,
  output logic [7:0]      cmd_o,
  // Converter pins
  input  wire logic       start_i,
  output logic            done_o,
  output logic [7:0]      data_o
);
  int pend = 0;
  initial begin
    {bit_clk_o, frame_o, hr_clk_o, cmd_stb_o, done_o} = 5'h00;
    cmd_o = 8'h00;
    data_o = 8'h00;
  end
  // The hi-rate reference runs free; the bit clock moves only inside frames.
  always begin
    repeat (6) @(negedge core_clk_i);
    hr_clk_o = ~hr_clk_o;
  end
  task automatic send_cmd(input logic [7:0] c);
    @(negedge core_clk_i) cmd_o = c;
    repeat (2) @(negedge core_clk_i);
    cmd_stb_o = 1'b1;
    repeat (6) @(negedge core_clk_i);
    cmd_stb_o = 1'b0;
    repeat (6) @(negedge core_clk_i);
    cmd_o = ~c;
  endtask
  task automatic frame;
    @(negedge core_clk_i) frame_o = 1'b1;
    repeat (6) @(negedge core_clk_i);
    frame_o = 1'b0;
  endtask
  task automatic bit_edge;
    @(negedge core_clk_i) bit_clk_o = 1'b1;
    repeat (6) @(negedge core_clk_i);
    bit_clk_o = 1'b0;
    repeat (5) @(negedge core_clk_i);
  endtask
  // Starts are counted so one that lands while done is still high is not lost.
  always @(posedge core_clk_i) if (start_i) pend++;
  always begin
    @(negedge core_clk_i iff pend > 0);
    pend--;
    repeat ($urandom_range(1, 9)) @(negedge core_clk_i);
    data_o = 8'($urandom);
    @(negedge core_clk_i) done_o = 1'b1;
    repeat (6) @(negedge core_clk_i);
    done_o = 1'b0;
    repeat (2) @(negedge core_clk_i);
    data_o = ~data_o;
  end
endmodule

// ==== test/pwdf_monitor.sv ====
// Checker on pwdf_top ports: pulse widths and the pin edges behind each output except hr_data_o and wf_band_o.
// Assumes host and converter pins hold each high level for at least six clocks.
`timescale 1ns/1ns
module pwdf_monitor #(
  parameter int HR_BLOCK = 64
) (
  // Clock, reset and host pins
  input wire logic                 core_clk_i,
  input wire logic                 reset_i,
  input wire logic                 ce_i,
  input wire logic                 host_bit_clk_i,
  input wire logic                 host_frame_i,
  input wire logic                 host_hr_clk_i,
  input wire logic                 host_cmd_stb_i,
  input wire logic [7:0]           host_cmd_data_i,
  // Formatter outputs
  input wire logic                 lr_data_o,
  input wire logic                 lr_ready_o,
  input wire logic [7:0]           hr_data_o,
  input wire logic                 hr_valid_o,
  input wire logic                 adc_start_o,
  input wire logic [4:0]           adc_chan_o,
  // Converter and steering
  input wire logic                 adc_done_i,
  input wire logic [7:0]           adc_data_i,
  input wire logic [7:0]           wf_data_i,
  input wire pwdf_pkg::pwdf_band_t wf_band_o,
  input wire logic                 antenna_b_o,
  input wire logic                 cal_wave_o
);
  import pwdf_pkg::*;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  reset_idle_a: assert property ($fell(reset_i) |-> wf_band_o == BAND_MID && !lr_ready_o)
    else $error("outputs not idle after reset");
  start_pulse_a: assert property (adc_start_o |=> !adc_start_o)
    else $error("converter start longer than one cycle");
  start_cause_a: assert property (adc_start_o |-> $past(host_frame_i, 2) || $past(adc_done_i, 2))
    else $error("converter start without frame or done");
  chan_range_a: assert property (adc_start_o |-> adc_chan_o <= 5'h12)
    else $error("converter channel out of range");
  chan_hold_a: assert property ($changed(adc_chan_o) |-> adc_start_o)
    else $error("channel moved without a start");
  ready_cause_a: assert property ($rose(lr_ready_o) |-> $past(adc_done_i, 2))
    else $error("low-rate ready without a conversion");
  no_conv_shift_a: assert property (lr_ready_o |-> !adc_start_o)
    else $error("conversion while shifting");
  bit_cause_a: assert property ($past(lr_ready_o) && lr_ready_o && $changed(lr_data_o)
    |-> $past(host_bit_clk_i, 2))
    else $error("serial bit changed without a bit clock");
  hr_cause_a: assert property (hr_valid_o |-> $past(host_hr_clk_i, 2))
    else $error("hi-rate byte without a hi-rate clock edge");
  cal_cause_a: assert property ($changed(cal_wave_o) |-> $past(host_hr_clk_i, 2))
    else $error("calibration wave moved off a hi-rate clock edge");
  hr_spacing_a: assert property (hr_valid_o |=> !hr_valid_o [*8])
    else $error("hi-rate bytes too close");
  ant_cause_a: assert property ($changed(antenna_b_o) |-> $past(host_cmd_stb_i, 2))
    else $error("antenna moved without a command");
endmodule

bind pwdf_top pwdf_monitor #(.HR_BLOCK(HR_BLOCK)) u_mon (
  .core_clk_i(core_clk_i), .reset_i(reset_i), .ce_i(ce_i),
  .host_bit_clk_i(host_bit_clk_i), .host_frame_i(host_frame_i),
  .host_hr_clk_i(host_hr_clk_i), .host_cmd_stb_i(host_cmd_stb_i),
  .host_cmd_data_i(host_cmd_data_i), .lr_data_o(lr_data_o), .lr_ready_o(lr_ready_o),
  .hr_data_o(hr_data_o), .hr_valid_o(hr_valid_o), .adc_start_o(adc_start_o),
  .adc_chan_o(adc_chan_o), .adc_done_i(adc_done_i), .adc_data_i(adc_data_i),
  .wf_data_i(wf_data_i), .wf_band_o(wf_band_o), .antenna_b_o(antenna_b_o),
  .cal_wave_o(cal_wave_o)
);

// ==== test/pwdf_tb.sv ====
// Self-checking bench for pwdf_top: reset, refusal, modes, sync bytes, frames.
// Assumes pwdf_host_model plays the host and the converter.
`timescale 1ns/1ns
`include "pwdf_defs.svh"
module tb;
  import pwdf_pkg::*;
  logic       core_clk_i = 1'b0;
  logic       reset_i = 1'b1;
  logic       ce_i = 1'b1;
  logic [7:0] wf_data_i = 8'h00;
  logic       bclk, frm, hrc, stb, done, lr_data_o, lr_ready_o, hr_valid_o;
  logic       adc_start_o, antenna_b_o, cal_wave_o, cal_q;
  logic [7:0] cmd, adat, hr_data_o;
  logic [4:0] adc_chan_o;
  logic [7:0] conv [0:18];
  pwdf_band_t wf_band_o;
  int         fails = 0;
  int         check_count = 0;
  int         hr_idx = 0;
  int         hr_ticks = 0;
  int         last_gap = 0;
  int         starts = 0;
  int         cal_ticks = 0;
  bit         cal_on = 1'b1;
  bit         cal_chk = 1'b0;
  int         per [4] = '{`PWDF_TICKS_M1, `PWDF_TICKS_M2, `PWDF_TICKS_M3, `PWDF_TICKS_M3};
  pwdf_band_t bnd [4] = '{BAND_MID, BAND_HIGH, BAND_LOW, BAND_LOW};
  pwdf_top #(.HR_BLOCK(4)) u_dut (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .ce_i(ce_i), .host_bit_clk_i(bclk),
    .host_frame_i(frm), .host_hr_clk_i(hrc), .host_cmd_stb_i(stb),
    .host_cmd_data_i(cmd), .lr_data_o(lr_data_o), .lr_ready_o(lr_ready_o),
    .hr_data_o(hr_data_o), .hr_valid_o(hr_valid_o), .adc_start_o(adc_start_o),
    .adc_chan_o(adc_chan_o), .adc_done_i(done), .adc_data_i(adat),
    .wf_data_i(wf_data_i), .wf_band_o(wf_band_o), .antenna_b_o(antenna_b_o),
    .cal_wave_o(cal_wave_o)
  );
  pwdf_host_model u_host (
    .core_clk_i(core_clk_i), .bit_clk_o(bclk), .frame_o(frm), .hr_clk_o(hrc),
    .cmd_stb_o(stb), .cmd_o(cmd), .start_i(adc_start_o), .done_o(done), .data_o(adat)
  );
  initial forever #2 core_clk_i = ~core_clk_i;
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude;
    if (fails == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wait_bytes(input int n);
    int t;
    t = hr_idx + n;
    repeat (20000) if (hr_idx < t) @(negedge core_clk_i);
    check("bytes arrived", t, hr_idx);
  endtask
  always @(posedge hrc) begin
    wf_data_i <= 8'($urandom);
    hr_ticks++;
    cal_ticks++;
  end
  always @(posedge done) conv[adc_chan_o] = adat;
  // Outputs are read at the edge, before this edge's updates land.
  always @(posedge core_clk_i) begin
    if (adc_start_o === 1'b1) starts++;
    if (hr_valid_o === 1'b1) begin
      if (hr_idx % 4 == 0) check("sync first", `PWDF_SYNC0, hr_data_o);
      if (hr_idx % 4 == 1) check("sync second", `PWDF_SYNC1, hr_data_o);
      // The sample is the one that arrived with the counting hi-rate edge.
      if (hr_idx % 4 > 1) check("sample", wf_data_i, hr_data_o);
      hr_idx++;
      last_gap = hr_ticks;
      hr_ticks = 0;
    end
    // Flops are unknown before the first edge in reset, so ignore changes then.
    if (!reset_i && cal_wave_o !== cal_q) begin
      if (cal_chk) check("cal half period", `PWDF_CAL_HALF_TICKS, cal_ticks);
      cal_chk = cal_on;
      cal_ticks = 0;
      cal_q = cal_wave_o;
    end
  end
  initial begin
    #300000;
    fails++;
    conclude();
  end
  initial begin
    logic [159:0] bits;
    logic [7:0]   cw;
    logic [1:0]   pr;
    void'($urandom(25804));
    cal_q = 1'b0;
    repeat (2) @(posedge core_clk_i);
    @(negedge core_clk_i) reset_i = 1'b0;
    check("band at reset", BAND_MID, wf_band_o);
    check("ready at reset", 0, lr_ready_o);
    // A frame before any enable command must be ignored.
    u_host.frame();
    repeat (40) @(negedge core_clk_i);
    check("starts while disabled", 0, starts);
    check("bytes while disabled", 0, hr_idx);
    for (int m = 0; m < 4; m++) begin
      u_host.send_cmd({6'h38, 2'(m)});
      check("antenna", 1, antenna_b_o);
      check("band", bnd[m], wf_band_o);
      wait_bytes(2);
      wait_bytes(1);
      check("byte period", per[m], last_gap);
    end
    cal_on = 1'b0;
    cal_chk = 1'b0;
    cw = 8'hd9;
    u_host.send_cmd(cw);
    for (int f = 0; f < 4; f++) begin
      u_host.frame();
      repeat (3000) if (lr_ready_o !== 1'b1) @(negedge core_clk_i);
      check("ready rise", 1, lr_ready_o);
      for (int b = 0; b < 160; b++) begin
        u_host.bit_edge();
        bits = {bits[158:0], lr_data_o};
        if (b == 158) check("ready before last bit", 1, lr_ready_o);
      end
      pr = 2'(cw >> (6 - 2 * (f % 4)));
      check("status", {1'b1, 5'(f), pr}, bits[159:152]);
      check("engineering", conv[0], bits[151:144]);
      for (int w = 2; w < 20; w++) check("science", conv[w-1], bits[159-8*w -: 8]);
      check("ready after block", 0, lr_ready_o);
    end
    check("cal off", 0, cal_wave_o);
    conclude();
  end
endmodule
